// [verilog/shadow_port_defines.svh]
/*
 * Register map, field positions, reset values and sizes of the shadow data port.
 * Assumes byte addresses on a 32-bit APB bus, each register in one aligned word.
 */
`ifndef SHADOW_PORT_DEFINES_SVH
`define SHADOW_PORT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define ALIAS_WINDOW_BASE 32'h5000_1130
`define ALIAS_WINDOW_WORDS 5'd16
`define ALIAS_TWO_ADDR 32'h5000_1138
`define CTRL_ADDR 32'h5000_1180
`define LINE_STATUS_ADDR 32'h5000_1184
`define IRQ_STATUS_ADDR 32'h5000_1188
`define IRQ_ENABLE_ADDR 32'h5000_118c
`define IRQ_CLEAR_ADDR 32'h5000_1190

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define CTRL_FIFO_EN_BIT 0
`define CTRL_IR_MODE_BIT 1
`define LSTAT_DATA_READY_BIT 0
`define LSTAT_TX_HOLDING_EMPTY_FLAG_BIT 5
`define LSTAT_RX_COUNT_LSB 8
`define LSTAT_TX_COUNT_LSB 16
`define IRQ_RX_DATA_BIT 0
`define IRQ_OVERRUN_BIT 1
`define IRQ_TX_EMPTY_BIT 2
`define IRQ_TX_LOST_BIT 3

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define CTRL_RESET 2'h0
`define IRQ_ENABLE_RESET 4'h0
`define ALIAS_RESET 16'h0000
`define FIFO_DEPTH 5'd16

`endif

// [verilog/shadow_port_pkg.sv]
/*
 * Types shared by the shadow data port.
 * Assumes the constants of shadow_port_defines.svh.
 */
package shadow_port_pkg;
    typedef logic [7:0] data_byte_t;
    typedef logic [3:0] fifo_ptr_t;
    typedef logic [4:0] fifo_count_t;
    typedef logic [3:0] irq_bits_t;
endpackage

// [verilog/shadow_rx_tx_data.sv]
/*
 * Shadow receive/transmit data port of a UART with 16-entry receive and
 * transmit FIFOs, control, line status and interrupt registers, all on APB.
 * Assumes a serial receiver that offers whole bytes from the serial or the
 * infrared input, and a serial transmitter that takes whole bytes.
 */
`timescale 1ns/1ps
`include "shadow_port_defines.svh"

module shadow_rx_tx_data (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_serial_valid,
    input wire shadow_port_pkg::data_byte_t rx_serial_data,
    input wire logic rx_ir_valid,
    input wire shadow_port_pkg::data_byte_t rx_ir_data,
    output shadow_port_pkg::data_byte_t tx_data,
    output logic tx_serial_valid,
    output logic tx_ir_valid,
    input wire logic tx_ready,
    output logic irq
);
    import shadow_port_pkg::*;

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    data_byte_t rx_mem_q [16];
    data_byte_t rx_mem_d [16];
    data_byte_t tx_mem_q [16];
    data_byte_t tx_mem_d [16];
    fifo_ptr_t rx_rd_q, rx_rd_d, tx_rd_q, tx_rd_d;
    fifo_count_t rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
    logic fifo_en_q, fifo_en_d, ir_mode_q, ir_mode_d;
    irq_bits_t irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
    logic [31:0] prdata_q, prdata_d;
    logic err_q, err_d;

    function automatic fifo_ptr_t ptr_add(input fifo_ptr_t p, input fifo_count_t n);
        ptr_add = p + n[3:0];
    endfunction

    function automatic logic at_addr(input logic [31:0] a, input logic [31:0] reg_addr);
        at_addr = (a == reg_addr);
    endfunction

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic setup, access, rd_setup, wr_access;
    logic alias_hit, mapped;
    logic [31:0] alias_off;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign rd_setup = clk_en && setup && !pwrite;
    assign wr_access = clk_en && access && pwrite;
    assign alias_off = paddr - `ALIAS_WINDOW_BASE;
    // Any word of the window reaches the same data path, so bursts work.
    assign alias_hit = (alias_off[31:6] == 26'h0) && (alias_off[1:0] == 2'h0);
    assign mapped = alias_hit || at_addr(paddr, `CTRL_ADDR) || at_addr(paddr, `LINE_STATUS_ADDR)
                    || at_addr(paddr, `IRQ_STATUS_ADDR) || at_addr(paddr, `IRQ_ENABLE_ADDR)
                    || at_addr(paddr, `IRQ_CLEAR_ADDR);

    assign pready = access;
    assign pslverr = access && err_q;
    assign prdata = prdata_q;

    // ------------------------------------------------------------------------
    // Flags and events
    // ------------------------------------------------------------------------
    fifo_count_t limit;
    logic data_ready, tx_holding_empty_flag, mode_change;
    logic rx_in_valid, rx_pop, tx_push, tx_pop;
    data_byte_t rx_in;
    logic ev_rx, ev_overrun, ev_tx_empty, ev_tx_lost;

    assign limit = fifo_en_q ? `FIFO_DEPTH : 5'd1;
    assign data_ready = (rx_cnt_q != 5'd0);
    assign tx_holding_empty_flag = (tx_cnt_q == 5'd0);
    assign mode_change = wr_access && at_addr(paddr, `CTRL_ADDR) && (pwdata[`CTRL_FIFO_EN_BIT] != fifo_en_q);
    assign rx_in = ir_mode_q ? rx_ir_data : rx_serial_data;
    assign rx_in_valid = clk_en && (ir_mode_q ? rx_ir_valid : rx_serial_valid);
    assign rx_pop = rd_setup && alias_hit && data_ready;
    assign tx_push = wr_access && alias_hit;
    assign tx_pop = clk_en && !tx_holding_empty_flag && tx_ready;

    // Serial or infrared transmitter, chosen by the mode bit.
    assign tx_data = tx_mem_q[tx_rd_q];
    assign tx_serial_valid = !tx_holding_empty_flag && !ir_mode_q;
    assign tx_ir_valid = !tx_holding_empty_flag && ir_mode_q;

    // ------------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------------
    always_comb begin
        rx_mem_d = rx_mem_q;
        rx_rd_d = rx_rd_q;
        rx_cnt_d = rx_cnt_q;
        ev_rx = 1'b0;
        ev_overrun = 1'b0;
        if (rx_pop) begin
            rx_rd_d = rx_rd_q + 4'h1;
            rx_cnt_d = rx_cnt_q - 5'd1;
        end
        if (rx_in_valid) begin
            if ((rx_cnt_q < limit) || rx_pop) begin
                rx_mem_d[ptr_add(rx_rd_q, rx_cnt_q)] = rx_in;
                rx_cnt_d = rx_pop ? rx_cnt_q : rx_cnt_q + 5'd1;
                ev_rx = 1'b1;
            end else if (!fifo_en_q) begin
                rx_mem_d[rx_rd_q] = rx_in;
                ev_rx = 1'b1;
                ev_overrun = 1'b1;
            end else begin
                ev_overrun = 1'b1;
            end
        end
        if (mode_change) begin
            rx_rd_d = 4'h0;
            rx_cnt_d = 5'd0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                rx_mem_q[i] <= 8'h00;
            end
            rx_rd_q <= 4'h0;
            rx_cnt_q <= 5'd0;
        end else if (clk_en) begin
            rx_mem_q <= rx_mem_d;
            rx_rd_q <= rx_rd_d;
            rx_cnt_q <= rx_cnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------------
    always_comb begin
        tx_mem_d = tx_mem_q;
        tx_rd_d = tx_rd_q;
        tx_cnt_d = tx_cnt_q;
        ev_tx_lost = 1'b0;
        if (tx_pop) begin
            tx_rd_d = tx_rd_q + 4'h1;
            tx_cnt_d = tx_cnt_q - 5'd1;
        end
        if (tx_push) begin
            // Depth 16 with FIFOs on, a single holding byte with them off.
            if ((tx_cnt_q < limit) || tx_pop) begin
                tx_mem_d[ptr_add(tx_rd_q, tx_cnt_q)] = pwdata[7:0];
                tx_cnt_d = tx_pop ? tx_cnt_q : tx_cnt_q + 5'd1;
            end else if (!fifo_en_q) begin
                tx_mem_d[tx_rd_q] = pwdata[7:0];
            end else begin
                ev_tx_lost = 1'b1;
            end
        end
        if (mode_change) begin
            tx_rd_d = 4'h0;
            tx_cnt_d = 5'd0;
        end
    end

    // The head byte is held while the transmitter owns it, except that a repeated write with FIFOs off replaces it
    // and a control write that changes the FIFO enable bit drops it, before the transmitter takes it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                tx_mem_q[i] <= 8'h00;
            end
            tx_rd_q <= 4'h0;
            tx_cnt_q <= 5'd0;
        end else if (clk_en) begin
            tx_mem_q <= tx_mem_d;
            tx_rd_q <= tx_rd_d;
            tx_cnt_q <= tx_cnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Control and interrupt registers
    // ------------------------------------------------------------------------
    assign ev_tx_empty = tx_pop && (tx_cnt_d == 5'd0);

    always_comb begin
        fifo_en_d = fifo_en_q;
        ir_mode_d = ir_mode_q;
        irq_en_d = irq_en_q;
        irq_stat_d = irq_stat_q;
        if (wr_access && at_addr(paddr, `CTRL_ADDR)) begin
            fifo_en_d = pwdata[`CTRL_FIFO_EN_BIT];
            ir_mode_d = pwdata[`CTRL_IR_MODE_BIT];
        end
        if (wr_access && at_addr(paddr, `IRQ_ENABLE_ADDR)) begin
            irq_en_d = pwdata[3:0];
        end
        if (wr_access && at_addr(paddr, `IRQ_CLEAR_ADDR)) begin
            irq_stat_d = irq_stat_q & ~pwdata[3:0];
        end
        // A new event wins over a clear in the same cycle.
        if (ev_rx) begin
            irq_stat_d[`IRQ_RX_DATA_BIT] = 1'b1;
        end
        if (ev_overrun) begin
            irq_stat_d[`IRQ_OVERRUN_BIT] = 1'b1;
        end
        if (ev_tx_empty) begin
            irq_stat_d[`IRQ_TX_EMPTY_BIT] = 1'b1;
        end
        if (ev_tx_lost) begin
            irq_stat_d[`IRQ_TX_LOST_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_en_q <= 1'(`CTRL_RESET >> `CTRL_FIFO_EN_BIT);
            ir_mode_q <= 1'(`CTRL_RESET >> `CTRL_IR_MODE_BIT);
            irq_en_q <= `IRQ_ENABLE_RESET;
            irq_stat_q <= 4'h0;
        end else if (clk_en) begin
            fifo_en_q <= fifo_en_d;
            ir_mode_q <= ir_mode_d;
            irq_en_q <= irq_en_d;
            irq_stat_q <= irq_stat_d;
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    // ------------------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------------------
    always_comb begin
        prdata_d = prdata_q;
        err_d = err_q;
        if (clk_en && setup) begin
            err_d = !mapped;
            prdata_d = 32'h0000_0000;
            if (!pwrite) begin
                if (alias_hit) begin
                    // Head of the FIFO, or the single buffer byte with FIFOs off.
                    prdata_d = {24'h00_0000, rx_mem_q[rx_rd_q]};
                end else if (at_addr(paddr, `CTRL_ADDR)) begin
                    prdata_d[`CTRL_FIFO_EN_BIT] = fifo_en_q;
                    prdata_d[`CTRL_IR_MODE_BIT] = ir_mode_q;
                end else if (at_addr(paddr, `LINE_STATUS_ADDR)) begin
                    prdata_d[`LSTAT_DATA_READY_BIT] = data_ready;
                    prdata_d[`LSTAT_TX_HOLDING_EMPTY_FLAG_BIT] = tx_holding_empty_flag;
                    prdata_d[`LSTAT_RX_COUNT_LSB +: 5] = rx_cnt_q;
                    prdata_d[`LSTAT_TX_COUNT_LSB +: 5] = tx_cnt_q;
                end else if (at_addr(paddr, `IRQ_STATUS_ADDR)) begin
                    prdata_d[3:0] = irq_stat_q;
                end else if (at_addr(paddr, `IRQ_ENABLE_ADDR)) begin
                    prdata_d[3:0] = irq_en_q;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else if (clk_en) begin
            prdata_q <= prdata_d;
            err_q <= err_d;
        end
    end
endmodule // shadow_rx_tx_data

// [tb/shadow_port_props.sv]
/* Checker of the shadow data port, bound to its top module.
   Assumes the one clock pclk and the reset presetn of the port. */
`timescale 1ns/1ps
`include "shadow_port_defines.svh"
module shadow_port_props import shadow_port_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire data_byte_t tx_data,
    input wire logic tx_serial_valid,
    input wire logic tx_ir_valid,
    input wire logic tx_ready,
    input wire logic irq
);
    logic in_win;
    assign in_win = paddr >= `ALIAS_WINDOW_BASE && paddr <= `ALIAS_WINDOW_BASE + 32'h3c && paddr[1:0] == 2'h0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_wr_idle;
        psel && penable && pwrite && in_win && clk_en && !tx_serial_valid && !tx_ir_valid;
    endsequence
    sequence s_tx_wait;
        (tx_serial_valid || tx_ir_valid) && !tx_ready && clk_en && !(psel && pwrite);
    endsequence
    sequence s_mask_all;
        psel && penable && pwrite && clk_en && paddr == `IRQ_ENABLE_ADDR && pwdata[3:0] == 4'h0;
    endsequence
    a_ready_zero_wait: assert property (s_acc |-> pready)
        else $error("pready low in access");
    a_alias_no_err: assert property (s_acc ##0 in_win |-> !pslverr)
        else $error("error on alias access");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_upper_zero: assert property (s_acc ##0 (in_win && !pwrite) |-> prdata[31:8] == 24'h0)
        else $error("upper alias bits not zero");
    a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_line_exclusive: assert property (!(tx_serial_valid && tx_ir_valid))
        else $error("both transmit lines valid");
    a_tx_after_wr: assert property (s_wr_idle |=> tx_serial_valid || tx_ir_valid)
        else $error("written byte not offered");
    a_tx_held: assert property (s_tx_wait |=> $stable(tx_data) && (tx_serial_valid || tx_ir_valid))
        else $error("pending byte not held");
    a_reset_quiet: assert property ($rose(presetn) |-> !irq && !tx_serial_valid && !tx_ir_valid)
        else $error("outputs active after reset");
    a_irq_masked: assert property (s_mask_all |=> !irq)
        else $error("irq high with all sources masked");
endmodule // shadow_port_props
bind shadow_rx_tx_data shadow_port_props u_props (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_data, .tx_serial_valid, .tx_ir_valid, .tx_ready, .irq);

// [tb/serial_partner.sv]
/* Far-side transceiver model: sends bytes on the serial or infrared receive path and takes sent bytes.
   Assumes the pclk domain of the port; the bench sets stall to hold off the transmitter. */
`timescale 1ns/1ps
module serial_partner import shadow_port_pkg::*; (
    input wire logic pclk,
    output logic rx_serial_valid = 1'h0,
    output data_byte_t rx_serial_data = 8'h00,
    output logic rx_ir_valid = 1'h0,
    output data_byte_t rx_ir_data = 8'h00,
    input wire data_byte_t tx_data,
    input wire logic tx_serial_valid,
    input wire logic tx_ir_valid,
    output logic tx_ready = 1'h0
);
    logic stall = 1'h0;
    logic [8:0] got[$];
    // Both data lines invert after a send; the line just used shows the inverse of its byte.
    task automatic send(input logic ir, input data_byte_t b);
        @(posedge pclk);
        if (ir) begin
            rx_ir_valid <= 1'h1;
            rx_ir_data <= b;
        end else begin
            rx_serial_valid <= 1'h1;
            rx_serial_data <= b;
        end
        @(posedge pclk);
        rx_ir_valid <= 1'h0;
        rx_serial_valid <= 1'h0;
        rx_ir_data <= ~rx_ir_data;
        rx_serial_data <= ~rx_serial_data;
    endtask
    always @(posedge pclk) begin
        tx_ready <= !stall;
        if ((tx_serial_valid || tx_ir_valid) && tx_ready) begin
            got.push_back({tx_ir_valid, tx_data});
        end
    end
endmodule // serial_partner

// [tb/test_shadow_rx_tx_data.sv]
/* Self-checking bench of the shadow data port over APB.
   Assumes the design, the far-side model and the checker compiled before it. */
`timescale 1ns/1ps
`include "shadow_port_defines.svh"
module test_shadow_rx_tx_data;
    import shadow_port_pkg::*;
    localparam logic [31:0] dr_m = 32'h1 << `LSTAT_DATA_READY_BIT;
    localparam logic [31:0] tx_holding_empty_flag_m = 32'h1 << `LSTAT_TX_HOLDING_EMPTY_FLAG_BIT;
    localparam logic [31:0] ovr_m = 32'h1 << `IRQ_OVERRUN_BIT;
    localparam logic [31:0] lost_m = 32'h1 << `IRQ_TX_LOST_BIT;
    localparam logic [31:0] rxd_m = 32'h1 << `IRQ_RX_DATA_BIT;
    localparam logic [31:0] empty_m = 32'h1 << `IRQ_TX_EMPTY_BIT;
    localparam logic [31:0] full = 32'(`FIFO_DEPTH);
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic clk_en = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, irq, tx_serial_valid, tx_ir_valid, rx_serial_valid, rx_ir_valid, tx_ready, rerr;
    data_byte_t tx_data, rx_serial_data, rx_ir_data;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 pclk = ~pclk;
    shadow_rx_tx_data dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_serial_valid, .rx_serial_data, .rx_ir_valid, .rx_ir_data, .tx_data,
        .tx_serial_valid, .tx_ir_valid, .tx_ready, .irq);
    serial_partner sp (.pclk, .rx_serial_valid, .rx_serial_data, .rx_ir_valid, .rx_ir_data, .tx_data,
        .tx_serial_valid, .tx_ir_valid, .tx_ready);
    task automatic results();
        $display("checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            results();
        end
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdm(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp, input string name);
        apb(1'h0, a, 32'h0);
        chk(name, exp, rdat & m);
    endtask
    task automatic wait_tx(input int n);
        for (int i = 0; i < 200 && sp.got.size() < n; i++) @(posedge pclk);
    endtask
    task automatic t_reset();
        rdm(`CTRL_ADDR, 32'hffff_ffff, 32'h0, "control");
        rdm(`IRQ_ENABLE_ADDR, 32'hf, 32'h0, "irq enable");
        rdm(`ALIAS_TWO_ADDR, 32'hffff_ffff, 32'h0, "alias reset");
        rdm(`LINE_STATUS_ADDR, dr_m | tx_holding_empty_flag_m, tx_holding_empty_flag_m, "line status");
        rdm(32'h5000_1100, 32'hffff_ffff, 32'h0, "unmapped data");
        chk("unmapped error", 32'h1, 32'(rerr));
    endtask
    task automatic t_freeze();
        clk_en <= 1'h0;
        sp.send(1'h0, 8'h77);
        clk_en <= 1'h1;
        rdm(`LINE_STATUS_ADDR, dr_m, 32'h0, "frozen receive");
    endtask
    task automatic t_rx_overrun();
        apb(1'h1, `IRQ_CLEAR_ADDR, 32'hf);
        apb(1'h1, `IRQ_ENABLE_ADDR, ovr_m);
        sp.send(1'h0, 8'h5a);
        rdm(`LINE_STATUS_ADDR, dr_m, dr_m, "data ready");
        chk("irq idle", 32'h0, 32'(irq));
        sp.send(1'h0, 8'ha5);
        rdm(`IRQ_STATUS_ADDR, ovr_m | rxd_m, ovr_m | rxd_m, "overrun");
        chk("irq raised", 32'h1, 32'(irq));
        rdm(`ALIAS_TWO_ADDR, 32'hffff_ffff, 32'ha5, "overwritten byte");
        rdm(`LINE_STATUS_ADDR, dr_m, 32'h0, "data ready clear");
        apb(1'h1, `IRQ_CLEAR_ADDR, ovr_m);
        @(posedge pclk);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'h1, `IRQ_ENABLE_ADDR, 32'h0);
    endtask
    task automatic t_ir();
        apb(1'h1, `CTRL_ADDR, 32'h1 << `CTRL_IR_MODE_BIT);
        apb(1'h1, `IRQ_CLEAR_ADDR, 32'hf);
        sp.send(1'h0, 8'h11);
        sp.send(1'h1, 8'h22);
        rdm(`IRQ_STATUS_ADDR, ovr_m, 32'h0, "no overrun");
        rdm(`ALIAS_TWO_ADDR, 32'hffff_ffff, 32'h22, "infrared byte");
        sp.got.delete();
        apb(1'h1, `ALIAS_TWO_ADDR, 32'hffff_ff3c);
        wait_tx(1);
        chk("infrared sent", 32'h13c, 32'(sp.got[0]));
        apb(1'h1, `CTRL_ADDR, 32'h0);
    endtask
    task automatic t_fifo_rx();
        apb(1'h1, `CTRL_ADDR, 32'h1);
        apb(1'h1, `IRQ_CLEAR_ADDR, 32'hf);
        for (int i = 0; i < 17; i++) sp.send(1'h0, 8'(8'h80 + i));
        rdm(`LINE_STATUS_ADDR, 32'h1f00, full << `LSTAT_RX_COUNT_LSB, "rx count");
        rdm(`IRQ_STATUS_ADDR, ovr_m, ovr_m, "fifo overrun");
        for (int i = 0; i < 16; i++) rdm(`ALIAS_WINDOW_BASE + 4 * i, 32'hffff_ffff, 32'h80 + i, "rx head");
        rdm(`LINE_STATUS_ADDR, dr_m, 32'h0, "rx drained");
    endtask
    task automatic t_tx_single();
        sp.stall <= 1'h1;
        apb(1'h1, `CTRL_ADDR, 32'h0);
        sp.got.delete();
        rdm(`LINE_STATUS_ADDR, tx_holding_empty_flag_m, tx_holding_empty_flag_m, "holding empty");
        apb(1'h1, `ALIAS_TWO_ADDR, 32'h41);
        rdm(`LINE_STATUS_ADDR, tx_holding_empty_flag_m, 32'h0, "holding full");
        apb(1'h1, `ALIAS_WINDOW_BASE + 32'h3c, 32'h42);
        sp.stall <= 1'h0;
        wait_tx(2);
        chk("tx bytes", 32'h1, 32'(sp.got.size()));
        chk("replaced byte", 32'h42, 32'(sp.got[0]));
    endtask
    task automatic t_tx_fifo();
        sp.stall <= 1'h1;
        apb(1'h1, `CTRL_ADDR, 32'h1);
        apb(1'h1, `IRQ_CLEAR_ADDR, 32'hf);
        sp.got.delete();
        for (int i = 0; i < 17; i++) apb(1'h1, `ALIAS_TWO_ADDR, 32'hc0 + i);
        rdm(`LINE_STATUS_ADDR, 32'h1f_0000, full << `LSTAT_TX_COUNT_LSB, "tx count");
        rdm(`IRQ_STATUS_ADDR, lost_m, lost_m, "tx lost");
        sp.stall <= 1'h0;
        wait_tx(17);
        chk("tx fifo bytes", full, 32'(sp.got.size()));
        for (int i = 0; i < 16; i++) chk("tx order", 32'hc0 + i, 32'(sp.got[i]));
        rdm(`IRQ_STATUS_ADDR, empty_m, empty_m, "tx drained");
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_freeze();
        t_rx_overrun();
        t_ir();
        t_fifo_rx();
        t_tx_single();
        t_tx_fifo();
        results();
    end
endmodule // test_shadow_rx_tx_data
